// ---- include/bpoc_pkg.sv ----
// Purpose: shared constants for the block protect and otp controller
// Assumes: ref_clk at 250 MHz
// Notes: register map is the controller's own apb window
package bpoc_pkg;
	localparam int CLK_NS = 4;
	localparam int WE_LOW_NS = 12;
	localparam int WE_HIGH_NS = 10;
	localparam int RE_LOW_NS = 12;
	localparam int RE_HIGH_NS = 10;
	localparam int BUSY_START_NS = 100;
	localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
	localparam int WE_HIGH_CYC = (WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
	localparam int RE_LOW_CYC = (RE_LOW_NS + CLK_NS - 1) / CLK_NS;
	localparam int RE_HIGH_CYC = (RE_HIGH_NS + CLK_NS - 1) / CLK_NS;
	localparam int BUSY_START_CYC = (BUSY_START_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ARG = 8'h04;
	localparam logic [7:0] OFS_DATA = 8'h08;
	localparam logic [7:0] OFS_STAT = 8'h0c;
	localparam int CTRL_START_BIT = 8;
	localparam int CTRL_WP_BIT = 16;
	localparam logic WP_RESET = 1'h1;
	localparam logic [7:0] CMD_LOCK_TIGHT = 8'h2c;
	localparam logic [7:0] CMD_BLK_STATUS = 8'h7a;
	localparam logic [7:0] CMD_EN0 = 8'h4c;
	localparam logic [7:0] CMD_EN1 = 8'h03;
	localparam logic [7:0] CMD_EN2 = 8'h1d;
	localparam logic [7:0] CMD_EN3 = 8'h41;
	localparam logic [7:0] CMD_PROG = 8'h80;
	localparam logic [7:0] CMD_CONFIRM = 8'h10;
	localparam logic [7:0] CMD_EXIT = 8'hff;
	localparam logic [7:0] CMD_STATUS = 8'h70;
	localparam logic [7:0] CMD_SET_FEAT = 8'hef;
	localparam logic [7:0] FEAT_OTP = 8'h90;
	localparam logic [7:0] MODE_NORMAL = 8'h00;
	localparam logic [7:0] MODE_OTP_OP = 8'h01;
	localparam logic [7:0] MODE_OTP_PROT = 8'h03;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [7:0] PROT_PASS = 8'he0;
	localparam logic [3:0] GROUP_MAX = 4'hb;
	localparam logic [7:0] OTP_PAGE_FIRST = 8'h02;
	localparam logic [7:0] OTP_PAGE_LAST = 8'h1f;
	localparam logic [7:0] LAST_PAGE_RESET = 8'h01;
	localparam logic [2:0] PARTIAL_MAX = 3'h4;
	typedef enum logic [2:0] {
		OP_LOCK_TIGHT = 3'b000, OP_BLK_STATUS = 3'b001, OP_GROUP_PROT = 3'b010,
		OP_OTP_MODE = 3'b011, OP_OTP_PROG = 3'b100, OP_OTP_PROT = 3'b101,
		OP_STATUS = 3'b110, OP_NONE = 3'b111
	} bpoc_op_t;
	typedef enum logic [2:0] {
		K_END = 3'b000, K_CMD = 3'b001, K_ADDR = 3'b010, K_DOUT = 3'b011,
		K_READ = 3'b100, K_WAIT = 3'b101
	} bpoc_kind_t;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000, S_LOW = 3'b001, S_HIGH = 3'b010, S_RDY = 3'b011
	} bpoc_state_t;
endpackage

// ---- rtl/bpoc_ctrl.sv ----
// Purpose: host sequencer for lock tight, block status, group protect and otp
// Assumes: apb slave for software; nand pins synchronous to ref_clk
// Notes: one op per start; pin sequence built from a step table
`timescale 1ns/1ns
`default_nettype none
module bpoc_ctrl (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic chip_sel_n,
	output logic cmd_latch,
	output logic addr_latch,
	output logic write_strobe_n,
	output logic read_strobe_n,
	output logic write_protect_n,
	output logic [7:0] io_out,
	output logic io_oe,
	input wire logic [7:0] io_in,
	input wire logic ready_busy_n
);
	typedef struct packed {
		bpoc_pkg::bpoc_state_t st;
		bpoc_pkg::bpoc_op_t op;
		logic [4:0] step;
		logic [7:0] cnt;
		logic wp;
		logic [31:0] arg;
		logic [15:0] dat;
		logic [7:0] rd;
		logic done;
		logic refused;
		logic otp_prot;
		logic prot_ok;
		logic [2:0] part;
		logic [7:0] last_pg;
		logic [7:0] last_cmd;
	} bpoc_regs_t;

	typedef struct packed {
		bpoc_pkg::bpoc_kind_t kind;
		logic [7:0] b;
	} bpoc_cyc_t;

	bpoc_regs_t state_reg;
	bpoc_regs_t state_next;
	bpoc_cyc_t cur;
	logic issue;
	logic drive;

	// ------------------------------------------------------------
	// step table
	// ------------------------------------------------------------
	function automatic bpoc_cyc_t cy(input bpoc_pkg::bpoc_kind_t k, input logic [7:0] b);
		bpoc_cyc_t c;
		c.kind = k;
		c.b = b;
		return c;
	endfunction

	function automatic bpoc_cyc_t seq(input bpoc_pkg::bpoc_op_t op, input logic [4:0] s,
		input logic [31:0] a, input logic [15:0] d);
		bpoc_cyc_t e;
		e = cy(bpoc_pkg::K_END, bpoc_pkg::ZERO_BYTE);
		case (op)
		bpoc_pkg::OP_LOCK_TIGHT: begin
			if (s == 5'h00) e = cy(bpoc_pkg::K_CMD, bpoc_pkg::CMD_LOCK_TIGHT);
		end
		bpoc_pkg::OP_BLK_STATUS: begin
			// invert bit held low in the first address byte
			case (s)
			5'h00: e = cy(bpoc_pkg::K_CMD, bpoc_pkg::CMD_BLK_STATUS);
			5'h01: e = cy(bpoc_pkg::K_ADDR, {a[1:0], 6'h00});
			5'h02: e = cy(bpoc_pkg::K_ADDR, a[9:2]);
			5'h03: e = cy(bpoc_pkg::K_ADDR, {6'h00, a[11:10]});
			5'h04: e = cy(bpoc_pkg::K_READ, bpoc_pkg::ZERO_BYTE);
			default: e = cy(bpoc_pkg::K_END, bpoc_pkg::ZERO_BYTE);
			endcase
		end
		bpoc_pkg::OP_GROUP_PROT: begin
			// back to back, nothing between enable bytes and 80h
			case (s)
			5'h00: e = cy(bpoc_pkg::K_CMD, bpoc_pkg::CMD_EN0);
			5'h01: e = cy(bpoc_pkg::K_CMD, bpoc_pkg::CMD_EN1);
			5'h02: e = cy(bpoc_pkg::K_CMD, bpoc_pkg::CMD_EN2);
			5'h03: e = cy(bpoc_pkg::K_CMD, bpoc_pkg::CMD_EN3);
			5'h04: e = cy(bpoc_pkg::K_CMD, bpoc_pkg::CMD_PROG);
			5'h05, 5'h06, 5'h07, 5'h09: e = cy(bpoc_pkg::K_ADDR, bpoc_pkg::ZERO_BYTE);
			5'h08: e = cy(bpoc_pkg::K_ADDR, {4'h0, a[3:0]});
			5'h0a: e = cy(bpoc_pkg::K_CMD, bpoc_pkg::CMD_CONFIRM);
			5'h0b: e = cy(bpoc_pkg::K_WAIT, bpoc_pkg::ZERO_BYTE);
			5'h0c: e = cy(bpoc_pkg::K_CMD, bpoc_pkg::CMD_STATUS);
			5'h0d: e = cy(bpoc_pkg::K_READ, bpoc_pkg::ZERO_BYTE);
			5'h0e: e = cy(bpoc_pkg::K_CMD, bpoc_pkg::CMD_EXIT);
			5'h0f: e = cy(bpoc_pkg::K_WAIT, bpoc_pkg::ZERO_BYTE);
			default: e = cy(bpoc_pkg::K_END, bpoc_pkg::ZERO_BYTE);
			endcase
		end
		bpoc_pkg::OP_OTP_MODE: begin
			case (s)
			5'h00: e = cy(bpoc_pkg::K_CMD, bpoc_pkg::CMD_SET_FEAT);
			5'h01: e = cy(bpoc_pkg::K_ADDR, bpoc_pkg::FEAT_OTP);
			5'h02: e = cy(bpoc_pkg::K_DOUT, d[7:0]);
			5'h03, 5'h04, 5'h05: e = cy(bpoc_pkg::K_DOUT, bpoc_pkg::ZERO_BYTE);
			5'h06: e = cy(bpoc_pkg::K_WAIT, bpoc_pkg::ZERO_BYTE);
			default: e = cy(bpoc_pkg::K_END, bpoc_pkg::ZERO_BYTE);
			endcase
		end
		bpoc_pkg::OP_OTP_PROG: begin
			case (s)
			5'h00: e = cy(bpoc_pkg::K_CMD, bpoc_pkg::CMD_PROG);
			5'h01: e = cy(bpoc_pkg::K_ADDR, a[23:16]);
			5'h02: e = cy(bpoc_pkg::K_ADDR, {3'h0, a[28:24]});
			5'h03: e = cy(bpoc_pkg::K_ADDR, a[7:0]);
			5'h04, 5'h05: e = cy(bpoc_pkg::K_ADDR, bpoc_pkg::ZERO_BYTE);
			5'h06: e = cy(bpoc_pkg::K_DOUT, d[15:8]);
			5'h07: e = cy(bpoc_pkg::K_CMD, bpoc_pkg::CMD_CONFIRM);
			5'h08: e = cy(bpoc_pkg::K_WAIT, bpoc_pkg::ZERO_BYTE);
			5'h09: e = cy(bpoc_pkg::K_CMD, bpoc_pkg::CMD_STATUS);
			5'h0a: e = cy(bpoc_pkg::K_READ, bpoc_pkg::ZERO_BYTE);
			default: e = cy(bpoc_pkg::K_END, bpoc_pkg::ZERO_BYTE);
			endcase
		end
		bpoc_pkg::OP_OTP_PROT: begin
			case (s)
			5'h00: e = cy(bpoc_pkg::K_CMD, bpoc_pkg::CMD_PROG);
			5'h01, 5'h02, 5'h03, 5'h04: e = cy(bpoc_pkg::K_ADDR, bpoc_pkg::ZERO_BYTE);
			5'h05, 5'h06: e = cy(bpoc_pkg::K_DOUT, bpoc_pkg::ZERO_BYTE);
			5'h07: e = cy(bpoc_pkg::K_CMD, bpoc_pkg::CMD_CONFIRM);
			5'h08: e = cy(bpoc_pkg::K_WAIT, bpoc_pkg::ZERO_BYTE);
			5'h09: e = cy(bpoc_pkg::K_CMD, bpoc_pkg::CMD_STATUS);
			5'h0a: e = cy(bpoc_pkg::K_READ, bpoc_pkg::ZERO_BYTE);
			default: e = cy(bpoc_pkg::K_END, bpoc_pkg::ZERO_BYTE);
			endcase
		end
		bpoc_pkg::OP_STATUS: begin
			if (s == 5'h00) e = cy(bpoc_pkg::K_CMD, bpoc_pkg::CMD_STATUS);
			else if (s == 5'h01) e = cy(bpoc_pkg::K_READ, bpoc_pkg::ZERO_BYTE);
		end
		default: e = cy(bpoc_pkg::K_END, bpoc_pkg::ZERO_BYTE);
		endcase
		return e;
	endfunction

	assign cur = seq(state_reg.op, state_reg.step, state_reg.arg, state_reg.dat);
	assign issue = (state_reg.st == bpoc_pkg::S_LOW) && (state_reg.cnt == 8'h00);
	assign drive = (state_reg.st == bpoc_pkg::S_LOW || state_reg.st == bpoc_pkg::S_HIGH) &&
		(cur.kind == bpoc_pkg::K_CMD || cur.kind == bpoc_pkg::K_ADDR || cur.kind == bpoc_pkg::K_DOUT);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic wr;
		logic ok;
		logic wp_now;
		logic [7:0] pg;
		logic [7:0] low_end;
		logic [7:0] high_end;
		bpoc_pkg::bpoc_op_t nop;
		state_next = state_reg;
		wr = psel && penable && pwrite;
		ok = 1'b0;
		wp_now = pwdata[bpoc_pkg::CTRL_WP_BIT];
		pg = state_reg.arg[7:0];
		nop = bpoc_pkg::bpoc_op_t'(pwdata[2:0]);
		low_end = (cur.kind == bpoc_pkg::K_READ) ? 8'(bpoc_pkg::RE_LOW_CYC - 1) : 8'(bpoc_pkg::WE_LOW_CYC - 1);
		high_end = (cur.kind == bpoc_pkg::K_READ) ? 8'(bpoc_pkg::RE_HIGH_CYC - 1) :
			8'(bpoc_pkg::WE_HIGH_CYC - 1);
		if (wr && state_reg.st == bpoc_pkg::S_IDLE) begin
			if (paddr == bpoc_pkg::OFS_CTRL) begin
				state_next.wp = wp_now;
				if (pwdata[bpoc_pkg::CTRL_START_BIT]) begin
					case (nop)
					bpoc_pkg::OP_LOCK_TIGHT: ok = wp_now;
					bpoc_pkg::OP_GROUP_PROT: ok = wp_now && state_reg.arg[3:0] <= bpoc_pkg::GROUP_MAX;
					bpoc_pkg::OP_OTP_MODE: ok = state_reg.dat[7:0] == bpoc_pkg::MODE_NORMAL ||
						state_reg.dat[7:0] == bpoc_pkg::MODE_OTP_OP ||
						state_reg.dat[7:0] == bpoc_pkg::MODE_OTP_PROT;
					bpoc_pkg::OP_OTP_PROG: ok = !state_reg.otp_prot && pg >= bpoc_pkg::OTP_PAGE_FIRST &&
						pg <= bpoc_pkg::OTP_PAGE_LAST && pg >= state_reg.last_pg &&
						!(pg == state_reg.last_pg && state_reg.part == bpoc_pkg::PARTIAL_MAX);
					bpoc_pkg::OP_NONE: ok = 1'b0;
					default: ok = 1'b1;
					endcase
					state_next.done = !ok;
					state_next.refused = !ok;
					if (ok) begin
						state_next.op = nop;
						state_next.step = 5'h00;
						state_next.cnt = 8'h00;
						state_next.st = bpoc_pkg::S_LOW;
						if (nop == bpoc_pkg::OP_OTP_PROG) begin
							state_next.last_pg = pg;
							state_next.part = (pg == state_reg.last_pg) ? state_reg.part + 3'h1 : 3'h1;
						end
					end
				end
			end else if (paddr == bpoc_pkg::OFS_ARG) begin
				state_next.arg = pwdata;
			end else if (paddr == bpoc_pkg::OFS_DATA) begin
				state_next.dat = pwdata[15:0];
			end
		end
		case (state_reg.st)
		bpoc_pkg::S_LOW: begin
			if (cur.kind == bpoc_pkg::K_END) begin
				state_next.st = bpoc_pkg::S_IDLE;
				state_next.done = 1'b1;
				if (state_reg.op == bpoc_pkg::OP_GROUP_PROT) begin
					state_next.prot_ok = state_reg.rd == bpoc_pkg::PROT_PASS;
				end
				if (state_reg.op == bpoc_pkg::OP_OTP_PROT && !state_reg.rd[0]) begin
					state_next.otp_prot = 1'b1;
				end
			end else if (cur.kind == bpoc_pkg::K_WAIT) begin
				state_next.cnt = state_reg.cnt + 8'h01;
				if (state_reg.cnt == 8'(bpoc_pkg::BUSY_START_CYC - 1)) begin
					state_next.st = bpoc_pkg::S_RDY;
				end
			end else if (state_reg.cnt == low_end) begin
				state_next.st = bpoc_pkg::S_HIGH;
				state_next.cnt = 8'h00;
				if (cur.kind == bpoc_pkg::K_READ) state_next.rd = io_in;
				if (cur.kind == bpoc_pkg::K_CMD) state_next.last_cmd = cur.b;
			end else begin
				state_next.cnt = state_reg.cnt + 8'h01;
			end
		end
		bpoc_pkg::S_HIGH: begin
			state_next.cnt = state_reg.cnt + 8'h01;
			if (state_reg.cnt == high_end) begin
				state_next.st = bpoc_pkg::S_LOW;
				state_next.cnt = 8'h00;
				state_next.step = state_reg.step + 5'h01;
			end
		end
		bpoc_pkg::S_RDY: begin
			if (ready_busy_n) begin
				state_next.st = bpoc_pkg::S_LOW;
				state_next.cnt = 8'h00;
				state_next.step = state_reg.step + 5'h01;
			end
		end
		default: ;
		endcase
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_reg <= '0;
			state_reg.wp <= bpoc_pkg::WP_RESET;
			state_reg.last_pg <= bpoc_pkg::LAST_PAGE_RESET;
		end else if (clk_en) begin
			state_reg <= state_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	always_comb begin
		prdata = 32'h0000_0000;
		if (psel && !pwrite) begin
			if (paddr == bpoc_pkg::OFS_CTRL) begin
				prdata = {15'h0000, state_reg.wp, 8'h00, 5'h00, 3'(state_reg.op)};
			end else if (paddr == bpoc_pkg::OFS_ARG) begin
				prdata = state_reg.arg;
			end else if (paddr == bpoc_pkg::OFS_DATA) begin
				prdata = {16'h0000, state_reg.dat};
			end else if (paddr == bpoc_pkg::OFS_STAT) begin
				prdata = {8'h00, state_reg.last_pg, state_reg.part, state_reg.prot_ok, state_reg.otp_prot,
					state_reg.refused, state_reg.done, state_reg.st != bpoc_pkg::S_IDLE, state_reg.rd};
			end
		end
	end

	assign pready = 1'b1;
	assign pslverr = psel && penable && paddr != bpoc_pkg::OFS_CTRL && paddr != bpoc_pkg::OFS_ARG &&
		paddr != bpoc_pkg::OFS_DATA && !(paddr == bpoc_pkg::OFS_STAT && !pwrite);
	assign chip_sel_n = state_reg.st == bpoc_pkg::S_IDLE;
	assign cmd_latch = drive && cur.kind == bpoc_pkg::K_CMD;
	assign addr_latch = drive && cur.kind == bpoc_pkg::K_ADDR;
	assign write_strobe_n = !(drive && state_reg.st == bpoc_pkg::S_LOW);
	assign read_strobe_n = !(state_reg.st == bpoc_pkg::S_LOW && cur.kind == bpoc_pkg::K_READ);
	assign write_protect_n = state_reg.wp;
	assign io_out = cur.b;
	assign io_oe = drive;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_tight_wp_high: assert property (@(posedge ref_clk) disable iff (reset)
		issue && cur.kind == bpoc_pkg::K_CMD && cur.b == bpoc_pkg::CMD_LOCK_TIGHT |-> write_protect_n)
		else $error("lock tight issued with write protect low");
	a_status_inv_low: assert property (@(posedge ref_clk) disable iff (reset)
		issue && state_reg.op == bpoc_pkg::OP_BLK_STATUS && state_reg.step == 5'h01 |-> addr_latch && !io_out[0])
		else $error("block status invert bit not low");
	a_protect_order: assert property (@(posedge ref_clk) disable iff (reset)
		issue && state_reg.op == bpoc_pkg::OP_GROUP_PROT && cmd_latch && io_out == bpoc_pkg::CMD_PROG
		|-> state_reg.last_cmd == bpoc_pkg::CMD_EN3)
		else $error("program setup not right after enable bytes");
	a_group_range: assert property (@(posedge ref_clk) disable iff (reset)
		issue && state_reg.op == bpoc_pkg::OP_GROUP_PROT && state_reg.step == 5'h08
		|-> addr_latch && io_out <= 8'h0b)
		else $error("group address out of range");
	a_feature_tail: assert property (@(posedge ref_clk) disable iff (reset)
		issue && state_reg.op == bpoc_pkg::OP_OTP_MODE && state_reg.step > 5'h02 && io_oe |-> io_out == 8'h00)
		else $error("feature tail parameter not zero");
	a_otp_ascend: assert property (@(posedge ref_clk) disable iff (reset)
		state_reg.st == bpoc_pkg::S_IDLE ##1 state_reg.st != bpoc_pkg::S_IDLE && state_reg.op == bpoc_pkg::OP_OTP_PROG
		|-> state_reg.last_pg >= $past(state_reg.last_pg) && state_reg.last_pg == state_reg.arg[7:0])
		else $error("otp page order broken");
	a_partial_max: assert property (@(posedge ref_clk) disable iff (reset)
		state_reg.part <= 3'h4)
		else $error("more than four partial programs");
	a_otp_prot_addr: assert property (@(posedge ref_clk) disable iff (reset)
		issue && state_reg.op == bpoc_pkg::OP_OTP_PROT && addr_latch |-> io_out == 8'h00)
		else $error("otp protect address not zero");
	a_we_width: assert property (@(posedge ref_clk) disable iff (reset || !clk_en)
		$fell(write_strobe_n) |-> !write_strobe_n [*3] ##1 write_strobe_n)
		else $error("write strobe low width wrong");
endmodule
`default_nettype wire

// ---- verif/bpoc_nand_model.sv ----
// Purpose: behavioural flash device behind the protect and otp controller
// Assumes: pins change on ref_clk edges; bytes land on write strobe rise
// Notes: every block starts locked; group bits survive reset
`timescale 1ns/1ns
`default_nettype none
module bpoc_nand_model #(parameter bit LOCK_STRAP = 1'b1) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic chip_sel_n,
	input wire logic cmd_latch,
	input wire logic addr_latch,
	input wire logic write_strobe_n,
	input wire logic read_strobe_n,
	input wire logic write_protect_n,
	input wire logic [7:0] io_out,
	input wire logic [7:0] busy_len,
	output logic [7:0] io_in,
	output logic ready_busy_n
);
	logic we_d, wp_d, tight, prot_arm, otp_prot, fail, pz, blk_prot;
	logic [2:0] en_cnt, acnt, pcnt;
	logic [3:0] dcnt;
	logic [7:0] cmd, dout, otp_last, feature_param_first, pf, bcnt;
	logic [7:0] adr [0:4];
	logic [11:0] groups;
	wire strobe = !chip_sel_n && !we_d && write_strobe_n;
	wire [7:0] b = io_out;
	wire otp_bad = otp_prot || adr[2] < 8'h02 || adr[2] > 8'h1f || adr[2] < otp_last
		|| (adr[2] == otp_last && pcnt == 3'h4);
	// released bus shows the inverse of the last byte
	assign io_in = (!chip_sel_n && !read_strobe_n) ? dout : ~dout;
	assign ready_busy_n = bcnt == 8'h0;
	// ----------------------------------------
	// byte decoder; groups deliberately not reset
	// ----------------------------------------
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			{we_d, wp_d, tight, prot_arm, otp_prot, fail, pz} <= 7'b1100000;
			{en_cnt, acnt, pcnt, dcnt} <= 13'h0;
			{cmd, dout, feature_param_first, pf, bcnt} <= 40'h0;
			blk_prot <= 1'b0;
			otp_last <= 8'h01;
		end else begin
			we_d <= write_strobe_n;
			wp_d <= write_protect_n;
			if (bcnt != 8'h0) bcnt <= bcnt - 8'h1;
			if (wp_d != write_protect_n) tight <= 1'b0;
			if (strobe && cmd_latch) begin
				cmd <= b;
				acnt <= 3'h0;
				dcnt <= 4'h0;
				en_cnt <= (b == 8'h4c) ? 3'h1 : (en_cnt == 3'h1 && b == 8'h03) ? 3'h2 :
					(en_cnt == 3'h2 && b == 8'h1d) ? 3'h3 : (en_cnt == 3'h3 && b == 8'h41) ? 3'h4 : 3'h0;
				if (b == 8'h2c && LOCK_STRAP) tight <= 1'b1;
				if (b == 8'h80) prot_arm <= en_cnt == 3'h4;
				if (b == 8'hff) prot_arm <= 1'b0;
				if (b == 8'h70) dout <= {!blk_prot, 7'h60} | {7'h0, fail};
				if (b == 8'h10 || b == 8'hff) bcnt <= busy_len;
				// no unlock here: a normal program always meets a locked block
				if (b == 8'h10) blk_prot <= LOCK_STRAP && !prot_arm && feature_param_first == 8'h00;
				if (b == 8'h10 && prot_arm) begin
					fail <= !write_protect_n || adr[3][3:0] > 4'hb
						|| (adr[0] | adr[1] | adr[2] | adr[4] | {4'h0, adr[3][7:4]}) != 8'h0;
					if (write_protect_n && adr[3][3:0] <= 4'hb) groups[adr[3][3:0]] <= 1'b1;
				end else if (b == 8'h10 && feature_param_first == 8'h01) begin
					fail <= otp_bad;
					if (!otp_bad) begin
						pcnt <= (adr[2] == otp_last) ? pcnt + 3'h1 : 3'h1;
						otp_last <= adr[2];
					end
				end else if (b == 8'h10 && feature_param_first == 8'h03) begin
					fail <= (adr[0] | adr[1] | adr[2] | adr[3]) != 8'h0;
					if ((adr[0] | adr[1] | adr[2] | adr[3]) == 8'h0) otp_prot <= 1'b1;
				end
			end
			if (strobe && addr_latch) begin
				en_cnt <= 3'h0;
				if (acnt < 3'h5) adr[acnt] <= b;
				acnt <= acnt + 3'h1;
				if (cmd == 8'h7a && acnt == 3'h2) dout <= tight ? 8'h01 : 8'h02;
			end
			if (strobe && !cmd_latch && !addr_latch) begin
				en_cnt <= 3'h0;
				dcnt <= dcnt + 4'h1;
				pz <= (dcnt == 4'h0) ? 1'b1 : pz && b == 8'h0;
				if (cmd == 8'hef && dcnt == 4'h0) pf <= b;
				if (cmd == 8'hef && dcnt == 4'h3) begin
					bcnt <= busy_len;
					if (pz && b == 8'h0 && (pf == 8'h0 || pf == 8'h1 || pf == 8'h3)) feature_param_first <= pf;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ---- verif/bpoc_ctrl_bench.sv ----
// Purpose: self-checking bench for the protect and otp controller
// Assumes: lock strap high at power-on; apb reads checked from a queue
// Notes: device busy time drawn at random per operation
`timescale 1ns/1ns
`default_nettype none
module bpoc_ctrl_bench;
	logic ref_clk = 0, reset = 1, clk_en = 1, psel = 0, penable = 0, pwrite = 0, chk_on = 0, perr;
	logic [7:0] paddr = 8'h0, busy_len = 8'h0, io_out, io_in;
	logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'hc353d7ec;
	logic pready, pslverr, chip_sel_n, cmd_latch, addr_latch, write_strobe_n, read_strobe_n;
	logic write_protect_n, io_oe, ready_busy_n;
	logic [7:0] bad_pg [3] = '{8'h02, 8'h01, 8'h20};
	logic [31:0] exp_q [$], msk_q [$];
	int err_total = 0, total_checks = 0;
	always #2 ref_clk = ~ref_clk;
	bpoc_ctrl dut (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.chip_sel_n(chip_sel_n), .cmd_latch(cmd_latch), .addr_latch(addr_latch), .write_strobe_n(write_strobe_n),
		.read_strobe_n(read_strobe_n), .write_protect_n(write_protect_n), .io_out(io_out), .io_oe(io_oe),
		.io_in(io_in), .ready_busy_n(ready_busy_n));
	bpoc_nand_model nand_dev (.ref_clk(ref_clk), .reset(reset), .chip_sel_n(chip_sel_n), .cmd_latch(cmd_latch),
		.addr_latch(addr_latch), .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
		.write_protect_n(write_protect_n), .io_out(io_out), .busy_len(busy_len), .io_in(io_in),
		.ready_busy_n(ready_busy_n));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		chk_on <= c;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		if (pready !== 1'b1) begin
			err_total++;
			end_of_test;
		end
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk_on <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		apb(1'b0, a, 32'h0, 1'b1);
	endtask
	task automatic run(input logic [2:0] op, input logic wp, input logic [31:0] arg, input logic [31:0] dat);
		int n;
		seed = xs(seed);
		busy_len <= {2'h0, seed[5:0]};
		apb(1'b1, bpoc_pkg::OFS_ARG, arg, 1'b0);
		apb(1'b1, bpoc_pkg::OFS_DATA, dat, 1'b0);
		apb(1'b1, bpoc_pkg::OFS_CTRL, {15'h0, wp, 7'h0, 1'b1, 5'h0, op}, 1'b0);
		repeat (2) @(posedge ref_clk);
		// random freeze while the op runs
		clk_en <= 1'b0;
		repeat (int'(seed[9:6]) + 1) @(posedge ref_clk);
		clk_en <= 1'b1;
		n = 0;
		do begin
			apb(1'b0, bpoc_pkg::OFS_STAT, 32'h0, 1'b0);
			n++;
		end while ((rd[9] !== 1'b1 || rd[8] !== 1'b0) && n < 5000);
		if (rd[9] !== 1'b1 || rd[8] !== 1'b0) begin
			err_total++;
			end_of_test;
		end
	endtask
	// queued expectations meet read data at the access edge
	always @(posedge ref_clk) begin
		if (psel && penable && !pwrite && chk_on && exp_q.size() > 0) begin
			check(prdata & msk_q[0], exp_q[0]);
			void'(exp_q.pop_front());
			void'(msk_q.pop_front());
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge ref_clk);
		reset <= 1'b0;
		rd_chk(bpoc_pkg::OFS_STAT, 32'h0, 32'h700);
		rd_chk(8'h10, 32'h0, 32'hffffffff);
		check({31'h0, perr}, 32'h1);
		apb(1'b1, bpoc_pkg::OFS_STAT, 32'h0, 1'b0);
		check({31'h0, perr}, 32'h1);
		seed = xs(seed);
		run(bpoc_pkg::OP_BLK_STATUS, 1'b1, {20'h0, seed[11:0]}, 32'h0);
		rd_chk(bpoc_pkg::OFS_STAT, 32'h202, 32'h607);
		run(bpoc_pkg::OP_LOCK_TIGHT, 1'b0, 32'h0, 32'h0);
		rd_chk(bpoc_pkg::OFS_STAT, 32'h600, 32'h600);
		run(bpoc_pkg::OP_LOCK_TIGHT, 1'b1, 32'h0, 32'h0);
		rd_chk(bpoc_pkg::OFS_STAT, 32'h200, 32'h600);
		run(bpoc_pkg::OP_BLK_STATUS, 1'b1, 32'h7ff, 32'h0);
		rd_chk(bpoc_pkg::OFS_STAT, 32'h201, 32'h607);
		apb(1'b1, bpoc_pkg::OFS_CTRL, 32'h0, 1'b0);
		apb(1'b1, bpoc_pkg::OFS_CTRL, 32'h10000, 1'b0);
		run(bpoc_pkg::OP_BLK_STATUS, 1'b1, 32'h0, 32'h0);
		rd_chk(bpoc_pkg::OFS_STAT, 32'h202, 32'h607);
		for (int g = 5; g <= 12; g++) begin
			if (g != 5 && g < 11) continue;
			run(bpoc_pkg::OP_GROUP_PROT, 1'b1, g, 32'h0);
			rd_chk(bpoc_pkg::OFS_STAT, (g > 11) ? 32'h600 : 32'h12e0, (g > 11) ? 32'h600 : 32'h16ff);
		end
		run(bpoc_pkg::OP_GROUP_PROT, 1'b0, 32'h0, 32'h0);
		rd_chk(bpoc_pkg::OFS_STAT, 32'h600, 32'h600);
		run(bpoc_pkg::OP_OTP_MODE, 1'b1, 32'h0, 32'h2);
		rd_chk(bpoc_pkg::OFS_STAT, 32'h600, 32'h600);
		run(bpoc_pkg::OP_OTP_MODE, 1'b1, 32'h0, 32'h1);
		rd_chk(bpoc_pkg::OFS_STAT, 32'h200, 32'h600);
		for (int k = 1; k <= 6; k++) begin
			seed = xs(seed);
			run(bpoc_pkg::OP_OTP_PROG, 1'b1, {3'h0, seed[12:0], 8'h0, (k == 6) ? 8'h03 : 8'h02}, {16'h0, seed[23:16], 8'h0});
			if (k == 5) rd_chk(bpoc_pkg::OFS_STAT, 32'h600, 32'h600);
			else rd_chk(bpoc_pkg::OFS_STAT, {8'h0, (k == 6) ? 8'h03 : 8'h02, (k == 6) ? 3'h1 : 3'(k), 13'h2e0}, 32'hffe6ff);
		end
		foreach (bad_pg[i]) begin
			run(bpoc_pkg::OP_OTP_PROG, 1'b1, {24'h0, bad_pg[i]}, 32'h0);
			rd_chk(bpoc_pkg::OFS_STAT, 32'h600, 32'h600);
		end
		run(bpoc_pkg::OP_OTP_MODE, 1'b1, 32'h0, 32'h3);
		run(bpoc_pkg::OP_OTP_PROT, 1'b1, 32'h0, 32'h0);
		rd_chk(bpoc_pkg::OFS_STAT, 32'hae0, 32'heff);
		run(bpoc_pkg::OP_OTP_MODE, 1'b1, 32'h0, 32'h1);
		run(bpoc_pkg::OP_OTP_PROG, 1'b1, 32'h4, 32'h0);
		rd_chk(bpoc_pkg::OFS_STAT, 32'h600, 32'h600);
		run(bpoc_pkg::OP_OTP_MODE, 1'b1, 32'h0, 32'h0);
		rd_chk(bpoc_pkg::OFS_STAT, 32'h200, 32'h600);
		run(bpoc_pkg::OP_STATUS, 1'b1, 32'h0, 32'h0);
		rd_chk(bpoc_pkg::OFS_STAT, 32'h2e0, 32'h6ff);
		run(bpoc_pkg::OP_OTP_PROT, 1'b1, 32'h0, 32'h0);
		rd_chk(bpoc_pkg::OFS_STAT, 32'h260, 32'h6ff);
		end_of_test;
	end
endmodule
`default_nettype wire
